// *** verilog/csw_pkg.sv ***
// Constants and types shared by the clock select control block.
package csw_pkg;
   localparam int          CSW_AW            = 8;
   localparam int          CSW_DW            = 8;
   // Register offsets.
   localparam logic [7:0]  CSW_SEL_OFS       = 8'h00;
   localparam logic [7:0]  CSW_STAT_OFS      = 8'h01;
   // Field positions of the clock source and wait select register.
   localparam int          CSW_LOOP_SEL_BIT  = 7;
   localparam int          CSW_OSC_STOP_BIT  = 6;
   localparam int          CSW_SYS_WAI_BIT   = 5;
   localparam int          CSW_AMP_WAI_BIT   = 4;
   localparam int          CSW_LOOP_WAI_BIT  = 3;
   localparam int          CSW_CORE_WAI_BIT  = 2;
   localparam int          CSW_TMR_WAI_BIT   = 1;
   localparam int          CSW_WDG_WAI_BIT   = 0;
   // Field positions of the status register.
   localparam int          CSW_ST_SRC_BIT    = 0;
   localparam int          CSW_ST_SCM_BIT    = 1;
   localparam int          CSW_ST_WAIT_BIT   = 2;
   localparam int          CSW_ST_STOP_BIT   = 3;
   localparam int          CSW_ST_AUTO_BIT   = 4;
   localparam int          CSW_ST_ONCE_BIT   = 5;
   // Reset values.
   localparam logic [7:0]  CSW_SEL_RST       = 8'h00;
   localparam logic [7:0]  CSW_RDATA_RST     = 8'h00;
   // The bus clock is the system clock source divided by this figure.
   localparam logic [1:0]  CSW_BUS_DIV       = 2'h2;

   // Power mode sequencer states.
   typedef enum logic [3:0] {
      CSW_RUN  = 4'h1,
      CSW_PREP = 4'h2,
      CSW_WAIT = 4'h4,
      CSW_STOP = 4'h8
   } csw_state_e;
endpackage

// *** verilog/csw_div.sv ***
// Bus clock enable divider: one pulse for every CSW_BUS_DIV enabled system clock cycles.
`timescale 1ns/100ps
module csw_div (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Control
   input  wire logic run,
   // Enable out
   output logic      bus_en
);
   import csw_pkg::*;

   logic [1:0] cnt;

   // A halted source also halts the divider, so no bus edge leaks out in wait.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 2'h0;
      end else if (run) begin
         if (cnt == CSW_BUS_DIV - 2'h1) begin
            cnt <= 2'h0;
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_en <= 1'b0;
      end else begin
         bus_en <= run && (cnt == CSW_BUS_DIV - 2'h1);
      end
   end
endmodule

// *** verilog/csw_once.sv ***
// Write-once storage bit that stays writable at any time in special modes.
`timescale 1ns/100ps
module csw_once (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Write side
   input  wire logic wr,
   input  wire logic din,
   input  wire logic special_mode,
   // State
   output logic      q,
   output logic      written
);
   // The lock is kept even in special modes, so leaving special mode does not
   // reopen the bit after a write already took place.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= 1'b0;
      end else if (wr && (special_mode || !written)) begin
         q <= din;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         written <= 1'b0;
      end else if (wr) begin
         written <= 1'b1;
      end
   end
endmodule

// *** verilog/csw_top.sv ***
// Clock source and wait select control with its register port and mode sequencer.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
// Functional notes
// R01: Setting loop select is ignored unless locked (auto) or tracking (manual).
// R02: Loop select clears on self-clock, stop, or wait entry with loop halt set.
// R03: Select zero uses oscillator clock, one uses loop clock; bus is half.
// R04: Oscillator stops in stop mode unless run-in-stop bit is set.
// R05: System clocks halt in wait when their bit is set; timer, watchdog unaffected.
// R06: Low amplitude bit requests reduced oscillator amplitude during wait.
// R07: Loop halt bit clears select before wait, powers loop down, power-on kept.
// R08: Select is not restored after wait; software must set it again.
// R09: Loop halt bit forces automatic bandwidth on so loop relocks itself.
// R10: Core clock stops in wait when core halt bit is set.
// R11: Timer stops and its dividers reset on wait entry when bit set.
// R12: Watchdog stops and its dividers reset on wait entry when bit set.
// R13: Watchdog bit accepts only the first write in normal modes.
// R14: Self-clock mode runs all clocks from loop clock at minimum frequency.
// R15: All eight select bits read back their current values at any time.
module csw_top (
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst,
   // Register port
   input  wire logic [csw_pkg::CSW_AW-1:0] addr,
   input  wire logic [csw_pkg::CSW_DW-1:0] wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output logic      [csw_pkg::CSW_DW-1:0] rdata,
   // Neighbouring loop status and mode inputs
   input  wire logic                      loop_locked,
   input  wire logic                      loop_tracking,
   input  wire logic                      auto_bandwidth,
   input  wire logic                      loop_power_on,
   input  wire logic                      self_clock_status,
   input  wire logic                      special_mode,
   input  wire logic                      wait_req,
   input  wire logic                      stop_req,
   // Clock source and gating
   output logic                           sys_src_loop,
   output logic                           bus_clk_en,
   output logic                           sys_clk_run,
   output logic                           core_clk_run,
   // Oscillator control
   output logic                           osc_enable,
   output logic                           osc_low_amp,
   // Loop control
   output logic                           loop_power_down,
   output logic                           auto_bw_force,
   // Periodic timer and watchdog control
   output logic                           timer_run,
   output logic                           timer_div_clear,
   output logic                           watchdog_run,
   output logic                           watchdog_div_clear,
   // Mode status
   output logic                           in_wait,
   output logic                           in_stop
);
   import csw_pkg::*;

   csw_state_e state;
   csw_state_e next_state;

   logic loop_clock_select;
   logic oscillator_run_in_stop;
   logic system_clock_halt_in_wait;
   logic low_amplitude_in_wait;
   logic loop_halt_in_wait;
   logic core_halt_in_wait;
   logic periodic_timer_halt_in_wait;
   logic watchdog_halt_in_wait;
   logic watchdog_written;

   logic wr_sel;
   logic auto_eff;
   logic loop_stable;
   logic sel_hw_clear;
   logic wait_entry;
   logic stop_entry;
   logic sys_run_now;
   logic div_en;
   logic [7:0] sel_value;
   logic [7:0] stat_value;

   // Offset decode, shared by the write path and both read paths.
   function automatic logic hit(input logic [CSW_AW-1:0] a, input logic [CSW_AW-1:0] ofs);
      return a == ofs;
   endfunction

   // Heading into wait with a given halt bit set; most wait gating hangs on this.
   function automatic logic wait_with(input csw_state_e s, input logic halt_bit);
      return (s == CSW_WAIT) && halt_bit;
   endfunction

   // Register selects and derived terms.
   assign wr_sel      = wr && hit(addr, CSW_SEL_OFS);
   assign auto_eff    = auto_bandwidth || loop_halt_in_wait; // R09
   assign loop_stable = auto_eff ? loop_locked : loop_tracking; // R01
   assign wait_entry  = (state == CSW_WAIT) && (next_state == CSW_WAIT) ? 1'b0 :
                        (next_state == CSW_WAIT) || (next_state == CSW_PREP);
   assign stop_entry  = (state != CSW_STOP) && (next_state == CSW_STOP);

   // Hardware clearing must beat a software set in the same cycle, since a set
   // that survived would put an unstable or powered-down loop on the system.
   assign sel_hw_clear = self_clock_status || stop_entry ||
                         (wait_entry && loop_halt_in_wait); // R02

   // Mode sequencer: a prep cycle drops the loop select before wait takes hold.
   always_comb begin
      next_state = state;
      case (state)
         CSW_RUN: begin
            if (stop_req) begin
               next_state = CSW_STOP;
            end else if (wait_req && loop_halt_in_wait) begin
               next_state = CSW_PREP; // R07
            end else if (wait_req) begin
               next_state = CSW_WAIT;
            end
         end
         CSW_PREP: begin
            next_state = wait_req ? CSW_WAIT : CSW_RUN;
         end
         CSW_WAIT: begin
            if (!wait_req) begin
               next_state = CSW_RUN; // R08
            end
         end
         CSW_STOP: begin
            if (!stop_req) begin
               next_state = CSW_RUN;
            end
         end
         default: begin
            next_state = CSW_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= CSW_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Loop clock select: guarded set, hardware clear, never restored by hardware.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         loop_clock_select <= CSW_SEL_RST[CSW_LOOP_SEL_BIT];
      end else if (sel_hw_clear) begin
         loop_clock_select <= 1'b0; // R02
      end else if (wr_sel) begin
         if (!wdata[CSW_LOOP_SEL_BIT]) begin
            loop_clock_select <= 1'b0;
         end else if (loop_stable) begin
            loop_clock_select <= 1'b1; // R01
         end
      end
   end

   // Freely writable control bits, one register each.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oscillator_run_in_stop <= CSW_SEL_RST[CSW_OSC_STOP_BIT];
      end else if (wr_sel) begin
         oscillator_run_in_stop <= wdata[CSW_OSC_STOP_BIT]; // R04
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         system_clock_halt_in_wait <= CSW_SEL_RST[CSW_SYS_WAI_BIT];
      end else if (wr_sel) begin
         system_clock_halt_in_wait <= wdata[CSW_SYS_WAI_BIT]; // R05
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_amplitude_in_wait <= CSW_SEL_RST[CSW_AMP_WAI_BIT];
      end else if (wr_sel) begin
         low_amplitude_in_wait <= wdata[CSW_AMP_WAI_BIT]; // R06
      end
   end

   // Writing this bit also moves the select guard onto the lock status.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         loop_halt_in_wait <= CSW_SEL_RST[CSW_LOOP_WAI_BIT];
      end else if (wr_sel) begin
         loop_halt_in_wait <= wdata[CSW_LOOP_WAI_BIT]; // R07
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         core_halt_in_wait <= CSW_SEL_RST[CSW_CORE_WAI_BIT];
      end else if (wr_sel) begin
         core_halt_in_wait <= wdata[CSW_CORE_WAI_BIT]; // R10
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         periodic_timer_halt_in_wait <= CSW_SEL_RST[CSW_TMR_WAI_BIT];
      end else if (wr_sel) begin
         periodic_timer_halt_in_wait <= wdata[CSW_TMR_WAI_BIT]; // R11
      end
   end

   // Watchdog halt bit is write-once outside special modes.
   csw_once u_wdg_once (
      .mclk         (mclk),
      .rst          (rst),
      .wr           (wr_sel),
      .din          (wdata[CSW_WDG_WAI_BIT]),
      .special_mode (special_mode),
      .q            (watchdog_halt_in_wait),
      .written      (watchdog_written)
   ); // R13

   // Read data, valid only in the cycle after the read strobe.
   assign sel_value = {loop_clock_select, oscillator_run_in_stop,
                       system_clock_halt_in_wait, low_amplitude_in_wait,
                       loop_halt_in_wait, core_halt_in_wait,
                       periodic_timer_halt_in_wait, watchdog_halt_in_wait}; // R15

   always_comb begin
      stat_value                  = 8'h00;
      stat_value[CSW_ST_SRC_BIT]  = sys_src_loop;
      stat_value[CSW_ST_SCM_BIT]  = self_clock_status;
      stat_value[CSW_ST_WAIT_BIT] = in_wait;
      stat_value[CSW_ST_STOP_BIT] = in_stop;
      stat_value[CSW_ST_AUTO_BIT] = auto_bw_force;
      stat_value[CSW_ST_ONCE_BIT] = watchdog_written;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata <= CSW_RDATA_RST;
      end else if (rd && hit(addr, CSW_SEL_OFS)) begin
         rdata <= sel_value; // R15
      end else if (rd && hit(addr, CSW_STAT_OFS)) begin
         rdata <= stat_value;
      end else begin
         rdata <= 8'h00;
      end
   end

   // Clock source: self-clock mode always runs from the loop at its floor.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sys_src_loop <= 1'b0;
      end else begin
         sys_src_loop <= self_clock_status || loop_clock_select; // R03 R14
      end
   end

   // System and core clock gating in the low-power modes.
   assign sys_run_now = !wait_with(next_state, system_clock_halt_in_wait) &&
                        (next_state != CSW_STOP);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sys_clk_run  <= 1'b1;
         core_clk_run <= 1'b1;
      end else begin
         sys_clk_run  <= sys_run_now; // R05
         core_clk_run <= sys_run_now &&
                         !wait_with(next_state, core_halt_in_wait); // R10
      end
   end

   // Bus clock enable at half the selected source rate.
   assign div_en = sys_run_now;

   csw_div u_bus_div (
      .mclk   (mclk),
      .rst    (rst),
      .run    (div_en),
      .bus_en (bus_clk_en)
   ); // R03

   // Oscillator enable and amplitude.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         osc_enable  <= 1'b1;
         osc_low_amp <= 1'b0;
      end else begin
         osc_enable  <= (next_state != CSW_STOP) || oscillator_run_in_stop; // R04
         osc_low_amp <= ((next_state == CSW_STOP) && oscillator_run_in_stop) || // R04
                        wait_with(next_state, low_amplitude_in_wait); // R06
      end
   end

   // Loop power: the power-on bit elsewhere stays set while the loop is down.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         loop_power_down <= 1'b0;
         auto_bw_force   <= 1'b0;
      end else begin
         loop_power_down <= !loop_power_on ||
                            wait_with(next_state, loop_halt_in_wait); // R07
         auto_bw_force   <= loop_halt_in_wait; // R09
      end
   end

   // Periodic timer and watchdog: run flags ignore the system halt bit.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timer_run    <= 1'b1;
         watchdog_run <= 1'b1;
      end else begin
         timer_run    <= !wait_with(next_state, periodic_timer_halt_in_wait); // R11
         watchdog_run <= !wait_with(next_state, watchdog_halt_in_wait); // R12
      end
   end

   // Divider clears are one-cycle pulses at each wait entry with the matching halt bit set.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timer_div_clear    <= 1'b0;
         watchdog_div_clear <= 1'b0;
      end else begin
         timer_div_clear    <= (state != CSW_WAIT) && (next_state == CSW_WAIT) &&
                               periodic_timer_halt_in_wait; // R11
         watchdog_div_clear <= (state != CSW_WAIT) && (next_state == CSW_WAIT) &&
                               watchdog_halt_in_wait; // R12
      end
   end

   // Mode status outputs.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_wait <= 1'b0;
         in_stop <= 1'b0;
      end else begin
         in_wait <= (next_state == CSW_WAIT);
         in_stop <= (next_state == CSW_STOP);
      end
   end
endmodule

// *** bench/csw_properties.sv ***
// Concurrent checks on the clock select control block ports.
`timescale 1ns/100ps
module csw_properties (
   // Clock and reset
   input wire logic                       mclk,
   input wire logic                       rst,
   // Register port
   input wire logic [csw_pkg::CSW_AW-1:0] addr,
   input wire logic                       rd,
   input wire logic [csw_pkg::CSW_DW-1:0] rdata,
   // Status inputs
   input wire logic                       loop_power_on,
   input wire logic                       self_clock_status,
   // Outputs watched
   input wire logic                       sys_src_loop,
   input wire logic                       bus_clk_en,
   input wire logic                       sys_clk_run,
   input wire logic                       core_clk_run,
   input wire logic                       loop_power_down,
   input wire logic                       timer_run,
   input wire logic                       timer_div_clear,
   input wire logic                       watchdog_run,
   input wire logic                       watchdog_div_clear,
   input wire logic                       in_wait,
   input wire logic                       in_stop
);
   import csw_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_wait_entry;
      $rose(in_wait);
   endsequence
   sequence s_stop_entry;
      $rose(in_stop) && !self_clock_status;
   endsequence
   a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside read answer");
   a_unmapped_read: assert property (rd && addr > 8'h01 |=> rdata == 8'h00)
      else $error("unmapped read returned data");
   a_self_clock_src: assert property (self_clock_status |=> sys_src_loop)
      else $error("self clock did not select loop source");
   a_stop_clears_src: assert property (s_stop_entry |=> !sys_src_loop)
      else $error("loop source kept after stop entry");
   a_bus_half_rate: assert property (bus_clk_en |=> !bus_clk_en)
      else $error("bus enable longer than one cycle");
   a_bus_en_pulses: assert property (sys_clk_run && !bus_clk_en && !$past(rst) |=> !sys_clk_run || bus_clk_en)
      else $error("bus enable missing while system clocks run");
   a_core_follows_sys: assert property (!sys_clk_run |-> !core_clk_run)
      else $error("core clock runs while system clocks halted");
   a_timer_clear_wait: assert property (timer_div_clear |-> in_wait && !timer_run)
      else $error("timer divider clear outside wait entry");
   a_wdg_clear_wait: assert property (watchdog_div_clear |-> in_wait && !watchdog_run)
      else $error("watchdog divider clear outside wait entry");
   a_clear_one_pulse: assert property (s_wait_entry |=> !timer_div_clear)
      else $error("timer divider clear longer than one cycle");
   a_loop_off_down: assert property (!loop_power_on |=> loop_power_down)
      else $error("loop not powered down while off");
   c_wait_entry: cover property (s_wait_entry);
endmodule
bind csw_top csw_properties u_props (
   .mclk(mclk), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata),
   .loop_power_on(loop_power_on), .self_clock_status(self_clock_status),
   .sys_src_loop(sys_src_loop), .bus_clk_en(bus_clk_en), .sys_clk_run(sys_clk_run),
   .core_clk_run(core_clk_run), .loop_power_down(loop_power_down), .timer_run(timer_run),
   .timer_div_clear(timer_div_clear), .watchdog_run(watchdog_run),
   .watchdog_div_clear(watchdog_div_clear), .in_wait(in_wait), .in_stop(in_stop)
);

// *** bench/testbench.sv ***
// Self-checking testbench for the clock select control block.
`timescale 1ns/100ps
module testbench;
   import csw_pkg::*;
   logic       mclk, rst, wr, rd;
   logic [7:0] addr, wdata, rdata, d;
   logic       loop_locked, loop_tracking, auto_bandwidth, loop_power_on;
   logic       self_clock_status, special_mode, wait_req, stop_req;
   logic       sys_src_loop, bus_clk_en, sys_clk_run, core_clk_run, osc_enable, osc_low_amp;
   logic       loop_power_down, auto_bw_force, timer_run, timer_div_clear;
   logic       watchdog_run, watchdog_div_clear, in_wait, in_stop;
   int         n_errors, comparisons, cycles;

   csw_top DUT (
      .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .loop_locked(loop_locked), .loop_tracking(loop_tracking),
      .auto_bandwidth(auto_bandwidth), .loop_power_on(loop_power_on),
      .self_clock_status(self_clock_status), .special_mode(special_mode),
      .wait_req(wait_req), .stop_req(stop_req), .sys_src_loop(sys_src_loop),
      .bus_clk_en(bus_clk_en), .sys_clk_run(sys_clk_run), .core_clk_run(core_clk_run),
      .osc_enable(osc_enable), .osc_low_amp(osc_low_amp), .loop_power_down(loop_power_down),
      .auto_bw_force(auto_bw_force), .timer_run(timer_run), .timer_div_clear(timer_div_clear),
      .watchdog_run(watchdog_run), .watchdog_div_clear(watchdog_div_clear),
      .in_wait(in_wait), .in_stop(in_stop)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // The ceiling is over twenty-five times the expected run length.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         print_verdict();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Raises or drops a mode request and waits a bounded time for the status.
   task mode(input bit stp, input bit on);
      int i;
      @(posedge mclk);
      if (stp) stop_req <= on;
      else wait_req <= on;
      for (i = 0; i < 10; i++) begin
         @(posedge mclk);
         #1;
         if ((stp ? in_stop : in_wait) === on) break;
      end
      chk({7'h00, stp ? in_stop : in_wait}, {7'h00, on});
   endtask

   task t_reset();
      chk({sys_clk_run, core_clk_run, osc_enable, timer_run, watchdog_run, in_wait, in_stop,
           sys_src_loop}, 8'hf8);
      rd_reg(CSW_SEL_OFS, d);
      chk(d, CSW_SEL_RST);
      rd_reg(8'h7f, d);
      chk(d, 8'h00);
      $display("reset test done");
   endtask

   // Loop select is refused unless the loop is stable for the bandwidth mode in use.
   task t_select();
      logic [2:0] f [3];
      int k;
      f = '{3'b100, 3'b010, 3'b110};
      for (k = 0; k < 3; k++) begin
         @(posedge mclk);
         {auto_bandwidth, loop_locked, loop_tracking} <= f[k];
         wr_reg(CSW_SEL_OFS, 8'h80);
         rd_reg(CSW_SEL_OFS, d);
         chk(d, k == 2 ? 8'h80 : 8'h00);
      end
      chk({7'h00, sys_src_loop}, 8'h01);
      @(posedge mclk);
      loop_power_on <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk({7'h00, loop_power_down}, 8'h01);
      @(posedge mclk);
      loop_power_on <= 1'b1;
      $display("select test done");
   endtask

   task t_once();
      wr_reg(CSW_SEL_OFS, 8'h81);
      rd_reg(CSW_SEL_OFS, d);
      chk(d, 8'h80);
      @(posedge mclk);
      special_mode <= 1'b1;
      wr_reg(CSW_SEL_OFS, 8'hbf);
      rd_reg(CSW_SEL_OFS, d);
      chk(d, 8'hbf);
      @(posedge mclk);
      special_mode <= 1'b0;
      $display("write once test done");
   endtask

   task t_wait();
      mode(1'b0, 1'b1);
      chk({timer_div_clear, watchdog_div_clear, timer_run, watchdog_run, sys_clk_run,
           core_clk_run, osc_low_amp, loop_power_down}, 8'hc3);
      @(posedge mclk);
      #1 chk({6'h00, timer_div_clear, watchdog_div_clear}, 8'h00);
      chk({6'h00, bus_clk_en, auto_bw_force}, 8'h01);
      rd_reg(CSW_STAT_OFS, d);
      chk(d, 8'h34);
      mode(1'b0, 1'b0);
      rd_reg(CSW_SEL_OFS, d);
      chk(d, 8'h3f);
      $display("wait test done");
   endtask

   task t_stop();
      int i;
      for (i = 0; i < 2; i++) begin
         wr_reg(CSW_SEL_OFS, i ? 8'hc0 : 8'h80);
         mode(1'b1, 1'b1);
         chk({5'h00, osc_enable, osc_low_amp, sys_clk_run}, i ? 8'h06 : 8'h00);
         mode(1'b1, 1'b0);
         rd_reg(CSW_SEL_OFS, d);
         chk(d, i ? 8'h41 : 8'h01);
      end
      $display("stop test done");
   endtask

   task t_scm();
      wr_reg(CSW_SEL_OFS, 8'h80);
      self_clock_status <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk({7'h00, sys_src_loop}, 8'h01);
      rd_reg(CSW_SEL_OFS, d);
      chk(d, 8'h01);
      @(posedge mclk);
      self_clock_status <= 1'b0;
      $display("self clock test done");
   endtask

   initial begin
      {wr, rd, addr, wdata} = '0;
      {loop_locked, loop_tracking, auto_bandwidth, self_clock_status} = '0;
      {special_mode, wait_req, stop_req} = '0;
      loop_power_on = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_select();
      t_once();
      t_wait();
      t_stop();
      t_scm();
      print_verdict();
   end
endmodule
